/* include/vid_seq_pkg.sv */
// Shared constants and types for the reference sequencer
package vid_seq_pkg;

  // ==========================================================
  // Register map (byte addresses) and field positions
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] INT_STAT_OFS = 12'h008;
  localparam logic [11:0] INT_MASK_OFS = 12'h00C;
  localparam int          ST_STATE_POS = 0;
  localparam int          ST_CLAMP_POS = 2;
  localparam int          ST_DRV_POS   = 3;
  localparam int          ST_CODE_POS  = 4;
  localparam int          ST_REF_POS   = 16;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [3:0]  MASK_RESET   = 4'h0;

  // ==========================================================
  // Interrupt event bits
  localparam int IRQ_W        = 4;
  localparam int EV_OVP       = 0;
  localparam int EV_SS_DONE   = 1;
  localparam int EV_VID_ACC   = 2;
  localparam int EV_BIAS_LOST = 3;

  // ==========================================================
  // Code sampling and debounce, in switching cycles or readings
  localparam int         VID_W           = 5;
  localparam logic [4:0] NO_LOAD_CODE    = 5'h1F;
  localparam int         SAMPLES_LEGACY  = 4;
  localparam int         SAMPLES_STEPPED = 6;
  localparam int         STABLE_CYCLES   = 12;
  localparam int         STEPPED_READS   = 3;
  localparam int         STEP_INTERVAL   = 4;
  localparam int         SS_DELAY        = 16;
  localparam int         SS_RAMP_PERIOD  = 16;

  // ==========================================================
  // Reference levels, one unit is the soft-start increment
  localparam int REF_W          = 9;
  localparam int REF_UNIT_UV    = 12500;
  localparam int LEGACY_STEP_UV = 25000;
  localparam int STEPPED_STEP_UV = 12500;
  localparam int OVP_MARGIN_UV  = 200000;
  localparam int FIXED_LOW_UV   = 1650000;
  localparam int FIXED_HIGH_UV  = 1950000;
  localparam int LEGACY_UNITS   = LEGACY_STEP_UV / REF_UNIT_UV;
  localparam int STEPPED_UNITS  = STEPPED_STEP_UV / REF_UNIT_UV;
  localparam int OVP_MARGIN_U   = OVP_MARGIN_UV / REF_UNIT_UV;
  localparam int FIXED_LOW_U    = FIXED_LOW_UV / REF_UNIT_UV;
  localparam int FIXED_HIGH_U   = FIXED_HIGH_UV / REF_UNIT_UV;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_LEGACY, MODE_ALTERNATE, MODE_STEPPED} mode_t;
  typedef enum logic [1:0] {SS_OFF, SS_DELAY_ST, SS_RAMP, SS_RUN} ss_state_t;

  typedef struct packed {
    logic vcc_ok;
    logic driver_bias_supply_ok;
    logic enable_ok;
    logic ovp_trip;
    logic ovp_release;
    logic fb_above_ref;
  } cmp_t;

  typedef struct packed {
    logic             phase;
    logic [VID_W-1:0] code;
    cmp_t             cmp;
  } pins_t;

  typedef struct packed {
    ss_state_t        st;
    logic [3:0]       cnt;
    logic [1:0]       step_cnt;
    logic [REF_W-1:0] ref_lvl;
    logic [REF_W-1:0] ovp_thr;
    logic             drv_on;
    logic             drive_en;
    logic             clamp;
    logic             gate_oe;
    logic             phase_prev;
    logic [1:0]       mode;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
    logic             pslverr;
  } seq_state_t;

endpackage : vid_seq_pkg

/* logic/pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Pins and synchronised copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // First stage feeds only the second
  always_comb begin
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule : pin_sync

/* logic/vid_debounce.sv */
// Code sampler and debouncer timed by the switching cycle
`timescale 1ns/1ps
module vid_debounce #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // Timing and setting
  input  wire logic                           phase_tick,
  input  wire logic                           stepped,
  // Code in and accepted code out
  input  wire logic [vid_seq_pkg::VID_W-1:0] code_in,
  output logic      [vid_seq_pkg::VID_W-1:0] code_out,
  output logic                                accept
);

  typedef struct packed {
    logic [CW-1:0]                  per_cnt;
    logic [CW-1:0]                  period;
    logic [CW-1:0]                  sub_cnt;
    logic [vid_seq_pkg::VID_W-1:0] cand;
    logic [vid_seq_pkg::VID_W-1:0] code;
    logic [3:0]                     stable;
    logic                           accept;
  } deb_t;

  deb_t          s_q;
  deb_t          s_d;
  logic [CW-1:0] interval;
  logic          sample;
  logic          settled;

  // Sub-cycle sample spacing from the last measured period
  always_comb begin
    s_d      = s_q;
    interval = stepped ? CW'((s_q.period + 1'b1) / CW'(vid_seq_pkg::SAMPLES_STEPPED))
                       : CW'((s_q.period + 1'b1) / CW'(vid_seq_pkg::SAMPLES_LEGACY));
    sample   = phase_tick || (CW'(s_q.sub_cnt + 1'b1) >= interval);
    s_d.per_cnt = phase_tick ? '0 : CW'(s_q.per_cnt + 1'b1);
    if (phase_tick) begin
      s_d.period = s_q.per_cnt;
    end
    s_d.sub_cnt = sample ? '0 : CW'(s_q.sub_cnt + 1'b1);
    // Stability count: readings when stepped, cycles otherwise
    if (sample && (code_in != s_q.cand)) begin
      s_d.cand   = code_in;
      s_d.stable = stepped ? 4'h1 : 4'h0;
    end else if (stepped && sample && (s_q.stable < 4'(vid_seq_pkg::STEPPED_READS))) begin
      s_d.stable = 4'(s_q.stable + 1'b1);
    end else if (!stepped && phase_tick && (s_q.stable < 4'(vid_seq_pkg::STABLE_CYCLES))) begin
      s_d.stable = 4'(s_q.stable + 1'b1);
    end
    settled = stepped ? (s_q.stable >= 4'(vid_seq_pkg::STEPPED_READS))
                      : (s_q.stable >= 4'(vid_seq_pkg::STABLE_CYCLES));
    s_d.accept = settled && (s_q.cand != s_q.code);
    if (s_d.accept) begin
      s_d.code = s_q.cand;
    end
  end

  // State register, starts at the no-load code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.cand <= vid_seq_pkg::NO_LOAD_CODE;
      s_q.code <= vid_seq_pkg::NO_LOAD_CODE;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_out = s_q.code;
  assign accept   = s_q.accept;

endmodule : vid_debounce

/* logic/vid_reference_sequencer.sv */
// Reference sequencer: start-up, soft-start, code tracking, clamp, APB
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Legacy/alternate: sample code four times per cycle
// - Legacy: accept code after 12 stable cycles
// - Legacy: step 25 mV every four cycles
// - Stepped: sample code six times per cycle
// - Stepped: three equal readings, jump reference directly
// - Low-side gates floated while bias below reset
// - Post-reset fixed threshold clamps low-side switches
// - Soft-start threshold: max(fixed, DAC+200mV), later DAC+200mV
// - Clamp holds until hysteresis release level
// - Clamp never latches, repeats on new crossing
// - Below bias thresholds all switches off
// - Code 11111 keeps converter disabled
// - Start at once when all conditions met
// - Wait 16 cycles before ramping reference
// - Ramp 12.5 mV every 16 cycles
// - Hold drives off while feedback above ramp
// - Pre-charged above target: enable at ramp end
module vid_reference_sequencer #(
  parameter logic [vid_seq_pkg::REF_W-1:0] REF_BASE_UNITS = 9'h094,
  parameter int                            PERIOD_W       = 16
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from the processor and the switching clock
  input  wire logic [4:0]  voltage_id_code,
  input  wire logic        phase_clk_in,
  // Comparator decisions
  input  wire logic        vcc_ok_in,
  input  wire logic        driver_bias_supply_ok_in,
  input  wire logic        threshold_enable_input,
  input  wire logic        overvoltage_guard_trip,
  input  wire logic        overvoltage_guard_release,
  input  wire logic        feedback_sense_above_ref,
  // Drive decisions and levels
  output logic             low_side_gate_on,
  output logic             low_side_gate_oe,
  output logic             drive_enable,
  output logic [8:0]       reference_target_voltage,
  output logic [8:0]       overvoltage_guard_threshold,
  output logic             irq
);

  // ==========================================================
  // Declarations
  vid_seq_pkg::seq_state_t          s_q;
  vid_seq_pkg::seq_state_t          s_d;
  vid_seq_pkg::pins_t               pins_raw;
  vid_seq_pkg::pins_t               pins;
  vid_seq_pkg::cmp_t                cmp;
  logic                             phase_tick;
  logic [vid_seq_pkg::VID_W-1:0]    code;
  logic                             accept;
  logic                             stepped;
  logic                             bias_ok;
  logic                             start_ok;
  logic [vid_seq_pkg::REF_W-1:0]    step_units;
  logic [vid_seq_pkg::REF_W-1:0]    target;
  logic [vid_seq_pkg::REF_W-1:0]    fixed_thr;
  logic [vid_seq_pkg::REF_W-1:0]    dac_thr;
  logic [vid_seq_pkg::REF_W-1:0]    ref_next;
  logic [vid_seq_pkg::IRQ_W-1:0]    events;
  logic [vid_seq_pkg::IRQ_W-1:0]    w1c;
  logic                             setup;
  logic                             wr;
  logic                             mapped;

  // ==========================================================
  // Pin synchronisation
  assign pins_raw.phase = phase_clk_in;
  assign pins_raw.code  = voltage_id_code;
  assign pins_raw.cmp   = '{vcc_ok:                vcc_ok_in,
                            driver_bias_supply_ok: driver_bias_supply_ok_in,
                            enable_ok:             threshold_enable_input,
                            ovp_trip:              overvoltage_guard_trip,
                            ovp_release:           overvoltage_guard_release,
                            fb_above_ref:          feedback_sense_above_ref};

  pin_sync #(
    .W ($bits(vid_seq_pkg::pins_t))
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // One tick per cycle
  assign cmp        = pins.cmp;
  assign phase_tick = pins.phase && !s_q.phase_prev;
  assign stepped    = (s_q.mode == vid_seq_pkg::MODE_STEPPED);

  // ==========================================================
  // Code sampling and debounce
  vid_debounce #(
    .CW (PERIOD_W)
  ) u_deb (
    .pclk       (pclk),
    .presetn    (presetn),
    .phase_tick (phase_tick),
    .stepped    (stepped),
    .code_in    (pins.code),
    .code_out   (code),
    .accept     (accept)
  );

  // ==========================================================
  // Target level and threshold candidates
  always_comb begin
    // Unit per code
    step_units = stepped ? vid_seq_pkg::REF_W'(vid_seq_pkg::STEPPED_UNITS)
                         : vid_seq_pkg::REF_W'(vid_seq_pkg::LEGACY_UNITS);
    target     = vid_seq_pkg::REF_W'(REF_BASE_UNITS
                 - vid_seq_pkg::REF_W'(code) * step_units);
    // Floor per setting
    fixed_thr  = (s_q.mode == vid_seq_pkg::MODE_LEGACY)
                 ? vid_seq_pkg::REF_W'(vid_seq_pkg::FIXED_HIGH_U)
                 : vid_seq_pkg::REF_W'(vid_seq_pkg::FIXED_LOW_U);
    dac_thr    = vid_seq_pkg::REF_W'(target
                 + vid_seq_pkg::REF_W'(vid_seq_pkg::OVP_MARGIN_U));
  end

  // Start conditions
  assign bias_ok  = cmp.vcc_ok && cmp.driver_bias_supply_ok;
  assign start_ok = bias_ok && cmp.enable_ok
                    && (code != vid_seq_pkg::NO_LOAD_CODE);

  // Legacy step toward the target, never overshooting
  always_comb begin
    // Last step partial
    if (s_q.ref_lvl < target) begin
      ref_next = ((target - s_q.ref_lvl) < step_units) ? target
                 : vid_seq_pkg::REF_W'(s_q.ref_lvl + step_units);
    end else begin
      ref_next = ((s_q.ref_lvl - target) < step_units) ? target
                 : vid_seq_pkg::REF_W'(s_q.ref_lvl - step_units);
    end
  end

  // ==========================================================
  // APB decode
  // Zero wait states
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign mapped = (paddr == vid_seq_pkg::CTRL_OFS)
                  || (paddr == vid_seq_pkg::STATUS_OFS)
                  || (paddr == vid_seq_pkg::INT_STAT_OFS)
                  || (paddr == vid_seq_pkg::INT_MASK_OFS);
  assign w1c    = (wr && (paddr == vid_seq_pkg::INT_STAT_OFS))
                  ? pwdata[vid_seq_pkg::IRQ_W-1:0] : '0;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d            = s_q;
    events         = '0;
    s_d.phase_prev = pins.phase;

    // Sequencer
    case (s_q.st)
      vid_seq_pkg::SS_OFF: begin
        s_d.ref_lvl  = '0;
        s_d.drv_on   = 1'b0;
        s_d.cnt      = '0;
        if (start_ok) begin
          s_d.st = vid_seq_pkg::SS_DELAY_ST;
        end
      end

      // Fixed delay
      vid_seq_pkg::SS_DELAY_ST: begin
        if (phase_tick) begin
          s_d.cnt = 4'(s_q.cnt + 1'b1);
          if (s_q.cnt == 4'(vid_seq_pkg::SS_DELAY - 1)) begin
            s_d.st  = vid_seq_pkg::SS_RAMP;
            s_d.cnt = '0;
          end
        end
      end

      // Linear ramp
      vid_seq_pkg::SS_RAMP: begin
        if (!cmp.fb_above_ref) begin
          s_d.drv_on = 1'b1;
        end
        if (s_q.ref_lvl >= target) begin
          s_d.ref_lvl = target;
          s_d.st      = vid_seq_pkg::SS_RUN;
          s_d.drv_on  = 1'b1;
          events[vid_seq_pkg::EV_SS_DONE] = 1'b1;
        end else if (phase_tick) begin
          s_d.cnt = 4'(s_q.cnt + 1'b1);
          if (s_q.cnt == 4'(vid_seq_pkg::SS_RAMP_PERIOD - 1)) begin
            s_d.ref_lvl = vid_seq_pkg::REF_W'(s_q.ref_lvl + 1'b1);
            s_d.cnt     = '0;
          end
        end
      end

      // Track the code
      vid_seq_pkg::SS_RUN: begin
        s_d.drv_on = 1'b1;
        if (stepped) begin
          s_d.ref_lvl  = target;
          s_d.step_cnt = '0;
        end else if (s_q.ref_lvl == target) begin
          s_d.step_cnt = '0;
        end else if (phase_tick) begin
          s_d.step_cnt = 2'(s_q.step_cnt + 1'b1);
          if (s_q.step_cnt == 2'(vid_seq_pkg::STEP_INTERVAL - 1)) begin
            s_d.ref_lvl = ref_next;
          end
        end
      end

      // Recover to off
      default: begin
        s_d.st = vid_seq_pkg::SS_OFF;
      end
    endcase

    // Loss of any start condition returns to off
    if (!start_ok) begin
      s_d.st     = vid_seq_pkg::SS_OFF;
      s_d.drv_on = 1'b0;
      // Restart from zero
      s_d.ref_lvl = '0;
      if (!bias_ok && (s_q.st != vid_seq_pkg::SS_OFF)) begin
        events[vid_seq_pkg::EV_BIAS_LOST] = 1'b1;
      end
    end

    // Threshold selection
    // Floor during start
    if (s_q.st == vid_seq_pkg::SS_RUN) begin
      s_d.ovp_thr = dac_thr;
    end else if (s_q.st == vid_seq_pkg::SS_OFF) begin
      s_d.ovp_thr = fixed_thr;
    end else begin
      s_d.ovp_thr = (dac_thr > fixed_thr) ? dac_thr : fixed_thr;
    end

    // Non-latching clamp after reset is released
    // Bias loss ends it
    s_d.clamp = bias_ok && (cmp.ovp_trip
                || (s_q.clamp && !cmp.ovp_release));
    if (s_d.clamp && !s_q.clamp) begin
      events[vid_seq_pkg::EV_OVP] = 1'b1;
    end
    if (accept) begin
      events[vid_seq_pkg::EV_VID_ACC] = 1'b1;
    end

    // Gate outputs
    // Core bias only
    s_d.gate_oe  = cmp.vcc_ok;
    s_d.drive_en = bias_ok && s_d.drv_on && !s_d.clamp;

    // Register writes, set wins over clear
    if (wr && (paddr == vid_seq_pkg::CTRL_OFS)) begin
      s_d.mode = pwdata[1:0];
    end
    if (wr && (paddr == vid_seq_pkg::INT_MASK_OFS)) begin
      s_d.irq_mask = pwdata[vid_seq_pkg::IRQ_W-1:0];
    end
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | events;

    // Read data latched in the setup phase
    // Stands to next setup
    if (setup) begin
      s_d.pslverr = !mapped;
      s_d.prdata  = '0;
      case (paddr)
        vid_seq_pkg::CTRL_OFS: begin
          s_d.prdata[1:0] = s_q.mode;
        end
        vid_seq_pkg::STATUS_OFS: begin
          s_d.prdata[vid_seq_pkg::ST_STATE_POS +: 2] = s_q.st;
          s_d.prdata[vid_seq_pkg::ST_CLAMP_POS]      = s_q.clamp;
          s_d.prdata[vid_seq_pkg::ST_DRV_POS]        = s_q.drive_en;
          s_d.prdata[vid_seq_pkg::ST_CODE_POS +: vid_seq_pkg::VID_W] = code;
          s_d.prdata[vid_seq_pkg::ST_REF_POS +: vid_seq_pkg::REF_W]  = s_q.ref_lvl;
        end
        vid_seq_pkg::INT_STAT_OFS: begin
          s_d.prdata[vid_seq_pkg::IRQ_W-1:0] = s_q.irq_stat;
        end
        vid_seq_pkg::INT_MASK_OFS: begin
          s_d.prdata[vid_seq_pkg::IRQ_W-1:0] = s_q.irq_mask;
        end
        default: begin
          s_d.prdata = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  // Package reset codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.st       <= vid_seq_pkg::SS_OFF;
      s_q.mode     <= vid_seq_pkg::CTRL_RESET;
      s_q.irq_mask <= vid_seq_pkg::MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // Flopped, pready tied high, irq a level
  assign pready                      = 1'b1;
  assign prdata                      = s_q.prdata;
  assign pslverr                     = s_q.pslverr;
  assign low_side_gate_on            = s_q.clamp;
  assign low_side_gate_oe            = s_q.gate_oe;
  assign drive_enable                = s_q.drive_en;
  assign reference_target_voltage    = s_q.ref_lvl;
  assign overvoltage_guard_threshold = s_q.ovp_thr;
  assign irq                         = |(s_q.irq_stat & s_q.irq_mask);

endmodule : vid_reference_sequencer

/* test/vid_cpu.sv */
// Processor model that drives the identification code pins
`timescale 1ns/1ps
module vid_cpu #(
  parameter int GAP = 40
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the bench
  input  wire logic [4:0] want_code,
  input  wire logic       one_step,
  // Code pins
  output logic      [4:0] voltage_id_code
);
  int wait_q;

  // Walk toward the wanted code, one code step per move when asked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_id_code <= 5'h1F;
      wait_q <= 0;
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else if (voltage_id_code != want_code) begin
      wait_q <= GAP;
      if (!one_step)
        voltage_id_code <= want_code;
      else if (voltage_id_code < want_code)
        voltage_id_code <= voltage_id_code + 5'h01;
      else
        voltage_id_code <= voltage_id_code - 5'h01;
    end
  end
endmodule : vid_cpu

/* test/seq_checker.sv */
// Port checks for the reference sequencer
`timescale 1ns/1ps
module seq_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  // Decisions in and out
  input wire logic        vcc_ok_in,
  input wire logic        driver_bias_supply_ok_in,
  input wire logic        threshold_enable_input,
  input wire logic        overvoltage_guard_trip,
  input wire logic        overvoltage_guard_release,
  input wire logic        low_side_gate_on,
  input wire logic        low_side_gate_oe,
  input wire logic        drive_enable,
  input wire logic [8:0]  reference_target_voltage
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Inputs need three edges to reach the outputs
  a_gate_float: assert property ((!vcc_ok_in) [*4] |-> !low_side_gate_oe)
    else $error("gates driven without bias");
  a_bias_off: assert property ((!driver_bias_supply_ok_in) [*4] |->
    !drive_enable && reference_target_voltage == 9'h000) else $error("runs without bias");
  a_enable_off: assert property ((!threshold_enable_input) [*4] |->
    !drive_enable && reference_target_voltage == 9'h000) else $error("runs while disabled");
  a_trip_clamps: assert property ((overvoltage_guard_trip && vcc_ok_in &&
    driver_bias_supply_ok_in) [*4] |-> low_side_gate_on) else $error("no clamp on trip");
  a_clamp_hold: assert property ($fell(low_side_gate_on) |->
    $past(overvoltage_guard_release, 3) || !$past(vcc_ok_in, 3) ||
    !$past(driver_bias_supply_ok_in, 3)) else $error("clamp dropped early");
  a_clamp_no_drive: assert property (low_side_gate_on |-> !drive_enable)
    else $error("drive on during clamp");
  a_ramp_pace: assert property (
    reference_target_voltage == $past(reference_target_voltage) + 9'h001 |=>
    $stable(reference_target_voltage) [*8]) else $error("reference steps too fast");
  a_bad_addr: assert property (psel && !penable && paddr > 12'h00C |=> pslverr)
    else $error("no error on unmapped address");
endmodule : seq_checker

bind vid_reference_sequencer seq_checker i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pslverr(pslverr), .vcc_ok_in(vcc_ok_in),
  .driver_bias_supply_ok_in(driver_bias_supply_ok_in),
  .threshold_enable_input(threshold_enable_input),
  .overvoltage_guard_trip(overvoltage_guard_trip),
  .overvoltage_guard_release(overvoltage_guard_release),
  .low_side_gate_on(low_side_gate_on), .low_side_gate_oe(low_side_gate_oe),
  .drive_enable(drive_enable), .reference_target_voltage(reference_target_voltage)
);

/* test/tb_top.sv */
// Self-checking bench for the reference sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int PH = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  want_code = 5'h1F;
  logic        one_step = 1'b0;
  logic [4:0]  vid;
  logic        phase = 1'b0;
  logic [2:0]  ph_cnt = 3'h0;
  logic        vcc_ok = 1'b0;
  logic        drv_ok = 1'b0;
  logic        en_ok = 1'b0;
  logic        trip = 1'b0;
  logic        rel = 1'b0;
  logic        fb_hi = 1'b1;
  logic        lsg_on, lsg_oe, drv_en, irq;
  logic [8:0]  ref_v, thr_v;
  logic [31:0] rd;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n;

  vid_reference_sequencer i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .voltage_id_code(vid), .phase_clk_in(phase), .vcc_ok_in(vcc_ok),
    .driver_bias_supply_ok_in(drv_ok), .threshold_enable_input(en_ok),
    .overvoltage_guard_trip(trip), .overvoltage_guard_release(rel),
    .feedback_sense_above_ref(fb_hi), .low_side_gate_on(lsg_on), .low_side_gate_oe(lsg_oe),
    .drive_enable(drv_en), .reference_target_voltage(ref_v),
    .overvoltage_guard_threshold(thr_v), .irq(irq));
  vid_cpu i_cpu (.pclk(pclk), .presetn(presetn), .want_code(want_code),
    .one_step(one_step), .voltage_id_code(vid));

  // Bus clock, switching clock of PH bus cycles, run limit
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    ph_cnt <= ph_cnt + 3'h1;
    phase <= (ph_cnt < 3'h4);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %0h wanted %0h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ref(input logic [8:0] v, input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (ref_v !== v && n < lim);
  endtask : wait_ref

  task automatic t_startup();
    apb(vid_seq_pkg::INT_MASK_OFS, 1'b0, 32'h0);
    check(rd, 32'h0);
    apb(12'h010, 1'b0, 32'h0);
    check(rd, 32'h0);
    @(posedge pclk);
    vcc_ok <= 1'b1;
    drv_ok <= 1'b1;
    en_ok <= 1'b1;
    repeat (40 * PH) @(negedge pclk);
    check(ref_v, 9'h000);
    @(posedge pclk);
    want_code <= 5'h1E;
    wait_ref(9'h001, 50 * PH);
    check(n >= 28 * PH && n <= 46 * PH, 1'b1);
    check(thr_v, vid_seq_pkg::FIXED_HIGH_U);
    check(drv_en, 1'b0);
    wait_ref(9'h002, 20 * PH);
    check(n, 16 * PH);
    wait_ref(9'h058, 90 * 16 * PH);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (drv_en !== 1'b1 && n < 20 * PH);
    check(drv_en, 1'b1);
    @(negedge pclk);
    check(thr_v, 9'h058 + vid_seq_pkg::OVP_MARGIN_U);
    apb(vid_seq_pkg::INT_MASK_OFS, 1'b1, 32'h2);
    fb_hi <= 1'b0;
    @(negedge pclk);
    check(irq, 1'b1);
    apb(vid_seq_pkg::INT_STAT_OFS, 1'b1, 32'h2);
    @(negedge pclk);
    check(irq, 1'b0);
  endtask : t_startup

  task automatic t_legacy_move();
    @(posedge pclk);
    want_code <= 5'h1C;
    repeat (10 * PH) @(negedge pclk);
    check(ref_v, 9'h058);
    wait_ref(9'h05A, 10 * PH);
    check(ref_v, 9'h05A);
    wait_ref(9'h05C, 8 * PH);
    check(n, 4 * PH);
  endtask : t_legacy_move

  task automatic t_clamp();
    @(posedge pclk);
    trip <= 1'b1;
    repeat (5) @(negedge pclk);
    check(lsg_on, 1'b1);
    @(posedge pclk);
    trip <= 1'b0;
    repeat (10) @(negedge pclk);
    check(lsg_on, 1'b1);
    @(posedge pclk);
    rel <= 1'b1;
    repeat (5) @(negedge pclk);
    check(lsg_on, 1'b0);
    check(drv_en, 1'b1);
    @(posedge pclk);
    rel <= 1'b0;
    trip <= 1'b1;
    repeat (5) @(negedge pclk);
    check(lsg_on, 1'b1);
    @(posedge pclk);
    trip <= 1'b0;
    rel <= 1'b1;
    repeat (5) @(negedge pclk);
    check(lsg_on, 1'b0);
    check(irq, 1'b0);
    apb(vid_seq_pkg::INT_STAT_OFS, 1'b0, 32'h0);
    check(rd[0], 1'b1);
  endtask : t_clamp

  task automatic t_stepped();
    apb(vid_seq_pkg::CTRL_OFS, 1'b1, 32'h2);
    @(posedge pclk);
    one_step <= 1'b1;
    want_code <= 5'h1E;
    wait_ref(9'h076, 200);
    check(ref_v, 9'h076);
    repeat (3) @(negedge pclk);
    check(thr_v, 9'h076 + vid_seq_pkg::OVP_MARGIN_U);
  endtask : t_stepped

  task automatic t_bias();
    @(posedge pclk);
    drv_ok <= 1'b0;
    repeat (5) @(negedge pclk);
    check(drv_en, 1'b0);
    check(ref_v, 9'h000);
    check(thr_v, vid_seq_pkg::FIXED_LOW_U);
    apb(vid_seq_pkg::INT_STAT_OFS, 1'b0, 32'h0);
    check(rd[3], 1'b1);
    @(posedge pclk);
    drv_ok <= 1'b1;
    vcc_ok <= 1'b0;
    repeat (5) @(negedge pclk);
    check(lsg_oe, 1'b0);
    @(posedge pclk);
    vcc_ok <= 1'b1;
    en_ok <= 1'b0;
    repeat (5) @(negedge pclk);
    check(ref_v, 9'h000);
  endtask : t_bias

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_startup();
    t_legacy_move();
    t_clamp();
    t_stepped();
    t_bias();
    tally_and_finish();
  end
endmodule : tb_top
